//--- design/fpba_defs.vh
// Constants for the fetch, pipeline and bank addressing core.
// Assumes a single 40 MHz core clock and an APB register port.
`ifndef FPBA_DEFS_VH
`define FPBA_DEFS_VH

// APB register byte offsets
`define FPBA_OFF_CTRL 12'h000
`define FPBA_OFF_BANK 12'h004
`define FPBA_OFF_WREG 12'h008
`define FPBA_OFF_PC 12'h00c
`define FPBA_OFF_STAT 12'h010

// Reset values
`define FPBA_RST_PC 21'h000000
`define FPBA_RST_BANK 4'h0
`define FPBA_RST_CTRL 1'b0
`define FPBA_RST_IR 16'h0000

// Phase codes, one-hot, bit 0 is phase_one
`define FPBA_PH_ONE 4'h1
`define FPBA_PH_TWO 4'h2
`define FPBA_PH_THREE 4'h4
`define FPBA_PH_FOUR 4'h8

// Program counter step in bytes
`define FPBA_PC_STEP 21'h000002

// Core registers seen in the data map
`define FPBA_ADDR_BANK 12'hfe0
`define FPBA_ADDR_WREG 12'hfe8
`define FPBA_ADDR_STAT 12'hfd8

// Quick access map split and upper bank
`define FPBA_QA_SPLIT 8'h80
`define FPBA_QA_HI_BANK 4'hf
`define FPBA_QA_LO_BANK 4'h0

// Opcode fields
`define FPBA_SECOND_TAG 4'hf
`define FPBA_OP_MOVE_FULL 4'hc
`define FPBA_OP_GOTO 8'hef
`define FPBA_OP_LOAD_BANK 8'h01
`define FPBA_OP_MOVLW 8'h0e
`define FPBA_OP_MOVWF 7'h37
`define FPBA_OP_MOVF 6'h14
`define FPBA_OP_ADDWF 6'h09
`define FPBA_OP_BRA 5'h1a

// Status flag positions
`define FPBA_ST_C 0
`define FPBA_ST_Z 2
`define FPBA_ST_N 4

`endif

//--- design/fpba_core.v
// Instruction sequencer and data address former of a small 8-bit core.
// Assumes synchronous program and data memories on clk with combinational
// read data, and an APB master for run control and observation.
// A stop request takes effect at the next instruction-cycle boundary.
//
// Behaviour
// - Input clock divided by four into phases one to four.
// - PC advances in phase one; next word latched in phase four.
// - Fetch overlaps execute; one instruction completes per cycle.
// - PC-changing instructions flush the prefetched word; a branch takes two cycles, a goto three.
// - IR loads phase one; operand read phase two; result written phase four.
// - Byte-addressed program memory; PC steps by two, bit zero zero.
// - Absolute jump loads word address into PC bits 20 down to 1.
// - Branch offset counts words, so PC moves twice the offset.
// - Second words carry 1111 on top, twelve literal bits below.
// - Lone 1111 word executes as no-operation.
// - Data addresses are 12 bits: sixteen banks of 256 bytes.
// - Unimplemented data locations read as zero.
// - Quick access map reaches core registers without bank_select.
// - Banked address is bank_select above the 8-bit offset.
// - Only four bank_select bits stored; upper four read zero.
// - load_bank_literal writes its immediate into bank_select.
// - Unimplemented bank writes dropped; status flags still update.
// - move_full_address uses full 12-bit addresses, ignoring bank_select.
// - Access bit one uses bank_select; zero uses quick access map.
// - Quick map low half is bank 0, high half bank 15.
`include "fpba_defs.vh"

module fpba_core #(
    parameter PC_W = 21,
    parameter DM_BANKS = 16
) (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [PC_W-1:0] pm_addr,
    output reg pm_rd,
    input wire [15:0] pm_rdata,
    output reg [11:0] dm_addr,
    output reg dm_rd,
    output reg dm_wr,
    output reg [7:0] dm_wdata,
    input wire [7:0] dm_rdata,
    output reg [3:0] phase
);

    // Run control from the register port
    reg run_reg;
    // Fetch stage: counter and the word latched in phase four
    reg [PC_W-1:0] pc_reg;
    reg [15:0] fetch_reg;
    // Execute stage: word under decode and whether it is a bubble
    reg [15:0] ir_reg;
    reg ir_valid_reg;
    reg flush_reg;
    // Pairing of two-word instructions; the first word parks its byte here
    reg pend_second_reg;
    reg in_second_reg;
    reg first_goto_reg;
    reg [7:0] hold_reg;
    // Core registers that also appear in the data map
    reg [3:0] bank_reg;
    reg [7:0] w_reg;
    reg [7:0] stat_reg;
    // Operand and pending write, carried from phase three to phase four
    reg [7:0] opnd_reg;
    reg [7:0] result_reg;
    reg [11:0] waddr_reg;
    reg wr_pend_reg;

    // Decode of the word in the instruction register
    reg is_lone;
    reg is_move_full;
    reg is_goto;
    reg is_load_bank;
    reg is_movlw;
    reg is_movwf;
    reg is_movf;
    reg is_addwf;
    reg is_bra;
    reg needs_read;
    reg [11:0] exec_addr;
    reg [8:0] sum;
    reg [7:0] rd_value;
    reg [31:0] apb_rdata;
    reg apb_hit;

    // Offset and access-select fields of a one-word instruction
    wire [7:0] off = ir_reg[7:0];
    wire acc_bit = ir_reg[8];
    // Register port phases; a write lands only in its access cycle
    wire apb_setup = psel & ~penable;
    wire apb_wr = psel & penable & pready & pwrite;
    // cycle boundary halt
    // A stop request lets the current cycle finish and parks in phase one,
    // so no strobe or half-done write is frozen; a stop costs up to 3 clocks
    wire seq_step = run_reg | (phase != `FPBA_PH_ONE);

    // Quick access or banked address, full address for moves
    always @* begin
        // lone second word
        // A tag word outside its pair must not touch memory
        is_lone = (ir_reg[15:12] == `FPBA_SECOND_TAG) && !in_second_reg;
        // Opcode matches; any word left unmatched runs as a no-operation
        is_move_full = ir_reg[15:12] == `FPBA_OP_MOVE_FULL;
        is_goto = ir_reg[15:8] == `FPBA_OP_GOTO;
        is_load_bank = (ir_reg[15:8] == `FPBA_OP_LOAD_BANK) && (ir_reg[7:4] == 4'h0);
        is_movlw = ir_reg[15:8] == `FPBA_OP_MOVLW;
        is_movwf = ir_reg[15:9] == `FPBA_OP_MOVWF;
        is_movf = ir_reg[15:10] == `FPBA_OP_MOVF;
        is_addwf = ir_reg[15:10] == `FPBA_OP_ADDWF;
        is_bra = ir_reg[15:11] == `FPBA_OP_BRA;
        // Data address: second-word literal, full move, banked or quick map
        // full address move
        if (in_second_reg) begin
            exec_addr = ir_reg[11:0];
        end else if (is_move_full) begin
            exec_addr = ir_reg[11:0];
        end else if (acc_bit) begin
            exec_addr = {bank_reg, off};
        end else if (off < `FPBA_QA_SPLIT) begin
            exec_addr = {`FPBA_QA_LO_BANK, off};
        end else begin
            exec_addr = {`FPBA_QA_HI_BANK, off};
        end
        // Only operand-reading instructions strobe the memory; second words never do
        needs_read = ir_valid_reg && !in_second_reg && !is_lone && (is_move_full || is_movf || is_addwf);
        // Carry kept in bit eight for the status flags
        sum = {1'b0, w_reg} + {1'b0, opnd_reg};
    end

    // Operand source: core registers, memory or zero
    // Core registers live in flops, so the array copy at their address is never read
    always @* begin
        if (dm_addr == `FPBA_ADDR_BANK) begin
            rd_value = {4'h0, bank_reg};
        end else if (dm_addr == `FPBA_ADDR_WREG) begin
            rd_value = w_reg;
        end else if (dm_addr == `FPBA_ADDR_STAT) begin
            rd_value = stat_reg;
        end else if ({28'h0, dm_addr[11:8]} >= DM_BANKS) begin
            rd_value = 8'h00;
        end else begin
            // Implemented bank: the byte strobed out in phase two
            rd_value = dm_rdata;
        end
    end

    // APB read mux, prepared in the setup cycle
    always @* begin
        // Unlisted offsets read zero and raise the error response
        apb_hit = 1'b1;
        case (paddr)
            `FPBA_OFF_CTRL: apb_rdata = {31'h0, run_reg};
            `FPBA_OFF_BANK: apb_rdata = {28'h0, bank_reg};
            `FPBA_OFF_WREG: apb_rdata = {24'h0, w_reg};
            `FPBA_OFF_PC: apb_rdata = {{(32-PC_W){1'b0}}, pc_reg};
            // Status word: instruction, flags, pairing and flush state, phase
            `FPBA_OFF_STAT: apb_rdata = {ir_reg, stat_reg, 1'b0, pend_second_reg, flush_reg, 1'b0, phase};
            default: begin
                apb_rdata = 32'h0;
                apb_hit = 1'b0;
            end
        endcase
    end

    // APB slave: zero wait states, error on unmapped address
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            run_reg <= `FPBA_RST_CTRL;
        end else begin
            // Answer one cycle after setup; an access phase without setup gets none
            pready <= apb_setup;
            pslverr <= apb_setup & ~apb_hit;
            // Read data captured at setup so it stands through the access cycle
            if (apb_setup) begin
                prdata <= apb_rdata;
            end
            // Writes to read-only or unmapped offsets fall through unused
            if (apb_wr && paddr == `FPBA_OFF_CTRL) begin
                run_reg <= pwdata[0];
            end
        end
    end

    // Phase sequencer and pipeline
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            phase <= `FPBA_PH_ONE;
            pc_reg <= `FPBA_RST_PC;
            fetch_reg <= `FPBA_RST_IR;
            ir_reg <= `FPBA_RST_IR;
            ir_valid_reg <= 1'b0;
            flush_reg <= 1'b1;
            pend_second_reg <= 1'b0;
            in_second_reg <= 1'b0;
            first_goto_reg <= 1'b0;
            hold_reg <= 8'h00;
            // Core registers start cleared
            bank_reg <= `FPBA_RST_BANK;
            w_reg <= 8'h00;
            stat_reg <= 8'h00;
            opnd_reg <= 8'h00;
            result_reg <= 8'h00;
            waddr_reg <= 12'h000;
            wr_pend_reg <= 1'b0;
            // Memory side idle until run is set
            pm_addr <= {PC_W{1'b0}};
            pm_rd <= 1'b0;
            dm_addr <= 12'h000;
            dm_rd <= 1'b0;
            dm_wr <= 1'b0;
            dm_wdata <= 8'h00;
        end else begin
            // Register port write to bank_select; core write below wins
            if (apb_wr && paddr == `FPBA_OFF_BANK) begin
                bank_reg <= pwdata[3:0];
            end
            if (seq_step) begin
                // divide by four
                // Each state lasts one clock; four make an instruction cycle
                phase <= {phase[2:0], phase[3]};
                case (phase)
                    `FPBA_PH_ONE: begin
                        ir_reg <= fetch_reg;
                        ir_valid_reg <= ~flush_reg;
                        in_second_reg <= pend_second_reg & ~flush_reg;
                        pend_second_reg <= 1'b0;
                        flush_reg <= 1'b0;
                        // write strobe ends
                        // The memory stored the byte at this edge; holding the strobe
                        // into phase three would write it again at the next operand address
                        dm_wr <= 1'b0;
                        pm_addr <= pc_reg;
                        pm_rd <= 1'b1;
                        pc_reg <= {pc_reg[PC_W-1:1] + 1'b1, 1'b0};
                    end
                    `FPBA_PH_TWO: begin
                        dm_addr <= exec_addr;
                        // Bubbles and lone second words leave the read strobe low
                        dm_rd <= needs_read;
                    end
                    `FPBA_PH_THREE: begin
                        // Operand taken while the read strobe still stands
                        opnd_reg <= rd_value;
                        dm_rd <= 1'b0;
                        // Write target and value settle here so phase four only drives pins
                        wr_pend_reg <= 1'b0;
                        if (ir_valid_reg && in_second_reg && !first_goto_reg) begin
                            waddr_reg <= ir_reg[11:0];
                            result_reg <= hold_reg;
                            wr_pend_reg <= 1'b1;
                        end else if (ir_valid_reg && !in_second_reg && !is_lone) begin
                            waddr_reg <= exec_addr;
                            if (is_movwf) begin
                                result_reg <= w_reg;
                                wr_pend_reg <= 1'b1;
                            end else if (is_movf && ir_reg[9]) begin
                                result_reg <= rd_value;
                                wr_pend_reg <= 1'b1;
                            end else if (is_addwf && ir_reg[9]) begin
                                result_reg <= w_reg + rd_value;
                                wr_pend_reg <= 1'b1;
                            end
                        end
                    end
                    `FPBA_PH_FOUR: begin
                        fetch_reg <= pm_rdata;
                        pm_rd <= 1'b0;
                        dm_wr <= 1'b0;
                        // Core registers take the byte instead of the array
                        if (wr_pend_reg) begin
                            dm_addr <= waddr_reg;
                            dm_wdata <= result_reg;
                            if (waddr_reg == `FPBA_ADDR_BANK) begin
                                bank_reg <= result_reg[3:0];
                            end else if (waddr_reg == `FPBA_ADDR_WREG) begin
                                w_reg <= result_reg;
                            end else if (waddr_reg == `FPBA_ADDR_STAT) begin
                                stat_reg <= result_reg;
                            end else if ({28'h0, waddr_reg[11:8]} < DM_BANKS) begin
                                dm_wr <= 1'b1;
                            end
                        end
                        if (ir_valid_reg && in_second_reg && first_goto_reg) begin
                            pc_reg <= {ir_reg[11:0], hold_reg, 1'b0};
                            flush_reg <= 1'b1;
                        end else if (ir_valid_reg && !in_second_reg && !is_lone) begin
                            if (is_move_full) begin
                                // pair with next word
                                // Source byte parked until the destination word arrives
                                hold_reg <= opnd_reg;
                                first_goto_reg <= 1'b0;
                                pend_second_reg <= 1'b1;
                            end else if (is_goto) begin
                                // Low eight target bits parked for the second word
                                hold_reg <= ir_reg[7:0];
                                first_goto_reg <= 1'b1;
                                pend_second_reg <= 1'b1;
                            end else if (is_load_bank) begin
                                bank_reg <= ir_reg[3:0];
                            end else if (is_movlw) begin
                                // Literal straight to the working register
                                w_reg <= ir_reg[7:0];
                            end else if (is_bra) begin
                                // twice the offset
                                // PC already two words past the branch, hence the step back
                                pc_reg <= pc_reg - `FPBA_PC_STEP + {{(PC_W-12){ir_reg[10]}}, ir_reg[10:0], 1'b0};
                                flush_reg <= 1'b1;
                            end else if (is_movf) begin
                                if (!ir_reg[9]) begin
                                    w_reg <= opnd_reg;
                                end
                                // Zero and negative from the operand; carry untouched
                                stat_reg[`FPBA_ST_Z] <= opnd_reg == 8'h00;
                                stat_reg[`FPBA_ST_N] <= opnd_reg[7];
                            end else if (is_addwf) begin
                                if (!ir_reg[9]) begin
                                    w_reg <= sum[7:0];
                                end
                                // Carry out of bit seven
                                stat_reg[`FPBA_ST_C] <= sum[8];
                                stat_reg[`FPBA_ST_Z] <= sum[7:0] == 8'h00;
                                stat_reg[`FPBA_ST_N] <= sum[7];
                            end
                        end
                    end
                    default: begin
                        // Recover from a corrupted ring
                        phase <= `FPBA_PH_ONE;
                    end
                endcase
            end else begin
                // Parked in phase one: drop a write strobe left from phase four
                dm_wr <= 1'b0;
            end
        end
    end

endmodule

//--- verification/fpba_core_monitor.sv
// Checker for the core: phase ring, fetch strobe and data strobes.
// Assumes it is bound to fpba_core and sees only that module's ports.
`include "fpba_defs.vh"
module fpba_core_monitor #(
    parameter PC_W = 21,
    parameter DM_BANKS = 16
) (
    input logic clk,
    input logic reset,
    input logic [PC_W-1:0] pm_addr,
    input logic pm_rd,
    input logic [11:0] dm_addr,
    input logic dm_rd,
    input logic dm_wr,
    input logic [3:0] phase
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Phase ring stays one-hot and only steps one place, so a halt may freeze it
    a_phase_onehot: assert property ($onehot(phase))
        else $error("phase not one-hot");
    a_phase_ring: assert property ((phase != $past(phase)) |-> phase == {$past(phase[2:0]), $past(phase[3])})
        else $error("phase skipped a step");
    // Fetch window opens after phase one and closes at the end of phase four
    a_pm_even: assert property (pm_addr[0] == 1'b0)
        else $error("odd program address");
    a_fetch_start: assert property ($rose(pm_rd) |-> phase == `FPBA_PH_TWO)
        else $error("fetch began off phase two");
    a_fetch_end: assert property ($fell(pm_rd) |-> phase == `FPBA_PH_ONE)
        else $error("fetch ended off phase four");
    // Operand read and result write are single pulses in fixed phases
    a_read_phase: assert property (dm_rd |-> phase == `FPBA_PH_THREE ##1 !dm_rd)
        else $error("operand read misplaced");
    a_write_phase: assert property (dm_wr |-> phase == `FPBA_PH_ONE ##1 !dm_wr)
        else $error("result write misplaced");
    a_write_legal: assert property (dm_wr |-> dm_addr[11:8] < DM_BANKS && dm_addr != `FPBA_ADDR_BANK
        && dm_addr != `FPBA_ADDR_WREG && dm_addr != `FPBA_ADDR_STAT)
        else $error("write reached an absent bank");
    c_write: cover property (dm_wr);
    c_read: cover property (dm_rd);
    c_fetch: cover property ($rose(pm_rd));
    c_wrap: cover property (phase == `FPBA_PH_ONE && $past(phase) == `FPBA_PH_FOUR);
endmodule

bind fpba_core fpba_core_monitor #(.PC_W(PC_W), .DM_BANKS(DM_BANKS)) fpba_core_monitor_i (.clk(clk),
    .reset(reset), .pm_addr(pm_addr), .pm_rd(pm_rd), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .phase(phase));

//--- verification/fpba_mem_model.sv
// Program and data memory arrays on the far side of the core.
// Assumes writes on the rising clk edge and reads that are live while selected.
module fpba_mem_model #(
    parameter PC_W = 21
) (
    input logic clk,
    input logic [PC_W-1:0] pm_addr,
    input logic pm_rd,
    output logic [15:0] pm_rdata,
    input logic [11:0] dm_addr,
    input logic dm_rd,
    input logic dm_wr,
    input logic [7:0] dm_wdata,
    output logic [7:0] dm_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] pm [0:255];
    logic [7:0] dm [0:4095];
    logic [15:0] pm_last = 16'h0000;
    logic [7:0] dm_last = 8'h00;
    // Blank program is no-operations; data starts at a marker value
    initial begin
        for (int i = 0; i < 4096; i++) begin
            dm[i] = 8'hee;
            if (i < 256) pm[i] = 16'h0000;
        end
    end
    // word per even byte address; 12-bit data space
    assign pm_rdata = pm_rd ? pm[pm_addr[8:1]] : ~pm_last;
    assign dm_rdata = dm_rd ? dm[dm_addr] : ~dm_last;
    // Released lines show inverted history so a stale sample cannot pass
    always @(posedge clk) begin
        if (pm_rd) pm_last <= pm[pm_addr[8:1]];
        if (dm_rd) dm_last <= dm[dm_addr];
        if (dm_wr) dm[dm_addr] <= dm_wdata;
    end
endmodule

//--- verification/fpba_core_tb.sv
// Self-checking bench: APB run control plus a short program in the model.
// Assumes a zero-wait APB slave and the memory model beside the core.
`include "fpba_defs.vh"
module fpba_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PC_W = 21;
    localparam int BANKS = 8;
    // Byte address and word of each program entry
    localparam logic [23:0] PROG [18] = '{24'h000e5a, 24'h020103, 24'h046f20, 24'h066e10, 24'h086e90,
        24'h0ac320, 24'h0cf456, 24'h0ef123, 24'h10ef10, 24'h12f000, 24'h140e11, 24'h20d002, 24'h220e22,
        24'h240e33, 24'h266e30, 24'h280107, 24'h2a5090, 24'h2cd7ff};
    // Data address and expected byte after the run
    localparam logic [19:0] DCHK [7] = '{20'h3205a, 20'h0205a ^ 20'h000b4, 20'h0105a, 20'h4565a, 20'h0305a,
        20'hf90ee, 20'h123ee};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [PC_W-1:0] pm_addr;
    wire pm_rd;
    wire [15:0] pm_rdata;
    wire [11:0] dm_addr;
    wire dm_rd;
    wire dm_wr;
    wire [7:0] dm_wdata;
    wire [7:0] dm_rdata;
    wire [3:0] phase;
    int fails = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic err;
    always #12.5 clk = ~clk;
    fpba_core #(.PC_W(PC_W), .DM_BANKS(BANKS)) fpba_core_i (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
        .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .phase(phase));
    fpba_mem_model #(.PC_W(PC_W)) fpba_mem_model_i (.clk(clk), .pm_addr(pm_addr), .pm_rd(pm_rd),
        .pm_rdata(pm_rdata), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata),
        .dm_rdata(dm_rdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            fails++;
            $display("[ERR] %0t no pready on the register port", $time);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic final_report();
        if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog far beyond the hundred or so cycles the program needs
    initial begin
        #100us;
        $display("[ERR] %0t watchdog expired", $time);
        fails++;
        final_report();
    end
    // Register checks while halted, then one program run, then results
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 18; i++) fpba_mem_model_i.pm[PROG[i][23:17]] = PROG[i][15:0];
        apb(1'b0, `FPBA_OFF_STAT, 32'h0);
        chk({28'h0, rd[3:0]}, {28'h0, `FPBA_PH_ONE});
        apb(1'b0, `FPBA_OFF_BANK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `FPBA_OFF_BANK, 32'h000000ff);
        apb(1'b0, `FPBA_OFF_BANK, 32'h0);
        chk(rd, 32'h0000000f);
        apb(1'b0, 12'h014, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, `FPBA_OFF_CTRL, 32'h1);
        for (int n = 0; n < 2000 && pm_addr !== 21'h00002c; n++) @(posedge clk);
        chk({11'h0, pm_addr}, 32'h0000002c);
        // Four instruction cycles of four phases let the last load finish
        repeat (16) @(posedge clk);
        apb(1'b1, `FPBA_OFF_CTRL, 32'h0);
        apb(1'b0, `FPBA_OFF_WREG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `FPBA_OFF_BANK, 32'h0);
        chk(rd, 32'h7);
        apb(1'b0, `FPBA_OFF_STAT, 32'h0);
        chk({30'h0, rd[`FPBA_ST_N + 8], rd[`FPBA_ST_Z + 8]}, 32'h1);
        apb(1'b0, `FPBA_OFF_PC, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        for (int i = 0; i < 7; i++) chk({24'h0, fpba_mem_model_i.dm[DCHK[i][19:8]]}, {24'h0, DCHK[i][7:0]});
        final_report();
    end
endmodule
